// *** flash_spm_pkg.sv ***
/*
 Package for the flash self-program sequencer: register offsets, control bit
 positions, command patterns, timing constants and carrier structs.
 Assumes a 10 MHz system clock and a 32-bit APB register bus.
*/
`default_nettype none

package flash_spm_pkg;

   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned PROG_MIN_NS    = 3_700_000;
   localparam int unsigned PROG_MAX_NS    = 4_500_000;
   localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
   // Midpoint of the window, rounded up
   localparam int unsigned PROG_CYCLES    = ((PROG_MIN_NS + PROG_MAX_NS) / 2 + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0]  SPM_WINDOW     = 3'h4;
   localparam logic [2:0]  LPM_WINDOW     = 3'h3;

   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int unsigned WORD_BITS      = 6;
   localparam int unsigned PAGE_BITS      = 8;
   localparam int unsigned PAGE_WORDS     = 1 << WORD_BITS;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL       = 12'h000;
   localparam logic [11:0] OFS_PTR        = 12'h004;
   localparam logic [11:0] OFS_DATA       = 12'h008;
   localparam logic [11:0] OFS_CMD        = 12'h00c;
   localparam logic [11:0] OFS_RESULT     = 12'h010;
   localparam logic [11:0] OFS_STATUS     = 12'h014;

   // -----------------------------------------------------------------
   // Control register bits
   // -----------------------------------------------------------------
   localparam int unsigned BIT_SPMEN      = 0;
   localparam int unsigned BIT_ERASE      = 1;
   localparam int unsigned BIT_WRITE      = 2;
   localparam int unsigned BIT_LFRD       = 3;
   localparam int unsigned BIT_FLUSH      = 4;
   localparam int unsigned BIT_IRQEN      = 7;

   localparam logic [7:0]  CMD_ERASE      = 8'h03;
   localparam logic [7:0]  CMD_LOAD       = 8'h01;
   localparam logic [7:0]  CMD_WRITE      = 8'h05;
   localparam logic [7:0]  CMD_LFRD       = 8'h09;
   localparam logic [3:0]  CMD_MASK       = 4'hf;

   // Command register codes
   localparam logic [1:0]  OP_STORE       = 2'h1;
   localparam logic [1:0]  OP_LOAD        = 2'h2;

   // Readback pointer values
   localparam logic [15:0] PTR_FUSE_LOW   = 16'h0000;
   localparam logic [15:0] PTR_LOCK       = 16'h0001;
   localparam logic [15:0] PTR_FUSE_EXT   = 16'h0002;
   localparam logic [15:0] PTR_FUSE_HIGH  = 16'h0003;

   // Status bits
   localparam int unsigned ST_BUSY        = 0;
   localparam int unsigned ST_IRQ         = 1;
   localparam int unsigned ST_DONE        = 2;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [PAGE_BITS-1:0] page;
      logic                 erase;
      logic                 write;
   } flash_op_t;

   typedef struct packed {
      logic                 psel;
      logic                 penable;
      logic                 pwrite;
      logic [11:0]          paddr;
      logic [31:0]          pwdata;
   } apb_req_t;

endpackage : flash_spm_pkg

`default_nettype wire

// *** page_buffer.sv ***
/*
 Temporary page buffer: one word per slot, random-order writes, whole
 buffer clear. Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module page_buffer #(
   parameter int unsigned WORDS = 64,
   parameter int unsigned AW    = 6
) (
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   input  wire logic          i_clear,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [15:0]   i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [15:0]   o_rdata,
   output logic      [AW:0]   o_count
);

   logic [15:0]    mem_r [WORDS];
   logic [WORDS-1:0] valid_r;
   logic [AW:0]    count_r;

   // -----------------------------------------------------------------
   // Storage, any slot in any order
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   // -----------------------------------------------------------------
   // Slot valid bits, erased slots read as all ones
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         valid_r <= '0;
         count_r <= '0;
      end
      else if (i_clear)
      begin
         valid_r <= '0;
         count_r <= '0;
      end
      else if (i_we && !valid_r[i_waddr])
      begin
         valid_r[i_waddr] <= 1'b1;
         count_r          <= count_r + 1'b1;
      end
   end

   assign o_rdata = valid_r[i_raddr] ? mem_r[i_raddr] : 16'hffff;
   assign o_count = count_r;

endmodule : page_buffer

`default_nettype wire

// *** flash_self_program_sequencer.sv ***
/*
 Flash self-program sequencer with APB register access. Holds the program
 memory control register, pointer and data pair, page buffer, a small flash
 array model and the fuse/lock readback path.
 Assumes the core raises store/load requests through the command register
 and obeys o_STALL.
*/
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_sequencer #(
   parameter int unsigned PROG_TIME  = flash_spm_pkg::PROG_CYCLES,
   parameter int unsigned WORD_BITS  = flash_spm_pkg::WORD_BITS,
   parameter int unsigned PAGE_BITS  = flash_spm_pkg::PAGE_BITS,
   parameter logic [7:0]  FUSE_LOW   = 8'h5a,   // Arbitrary value
   parameter logic [7:0]  FUSE_HIGH  = 8'h9e,   // Arbitrary value
   parameter logic [7:0]  FUSE_EXT   = 8'hf7,   // Arbitrary value
   parameter logic [7:0]  LOCK_BITS  = 8'h3c    // Arbitrary value
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RESET,
   input  wire logic        i_PSEL,
   input  wire logic        i_PENABLE,
   input  wire logic        i_PWRITE,
   input  wire logic [11:0] i_PADDR,
   input  wire logic [31:0] i_PWDATA,
   output logic      [31:0] o_PRDATA,
   output logic             o_PREADY,
   output logic             o_PSLVERR,
   input  wire logic        i_EEPROM_BUSY,
   output logic             o_STALL,
   output logic             o_READY_IRQ
);

   localparam int unsigned AW    = WORD_BITS + PAGE_BITS;
   localparam int unsigned NWORD = 1 << AW;
   localparam int unsigned TW    = $clog2(PROG_TIME + 1);

   typedef enum logic [1:0] {IDLE, ERASING, WRITING} seq_state_t;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   flash_spm_pkg::apb_req_t req;
   seq_state_t              state_r;
   seq_state_t              state_nxt;
   logic [7:0]              ctrl_r;
   logic [15:0]             ptr_r;
   logic [15:0]             data_r;
   logic [7:0]              result_r;
   logic                    done_r;
   logic [2:0]              win_r;
   logic [TW-1:0]           timer_r;
   logic [PAGE_BITS-1:0]    op_page_r;
   logic [15:0]             flash_r [NWORD];
   logic                    ee_s1_r;
   logic                    ee_s2_r;
   logic                    ee_prev_r;
   logic [31:0]             prdata_r;
   logic                    stall_r;
   logic                    irq_r;
   logic                    pready_r;
   logic                    pslverr_r;
   logic [WORD_BITS:0]      buf_count;
   logic [15:0]             buf_rdata;
   logic [WORD_BITS-1:0]    buf_raddr;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   assign req = '{psel: i_PSEL, penable: i_PENABLE, pwrite: i_PWRITE,
                  paddr: i_PADDR, pwdata: i_PWDATA};
   wire acc       = req.psel && req.penable && pready_r;
   wire wr        = acc && req.pwrite;
   wire wr_ctrl   = wr && req.paddr == flash_spm_pkg::OFS_CTRL;
   wire wr_ptr    = wr && req.paddr == flash_spm_pkg::OFS_PTR;
   wire wr_data   = wr && req.paddr == flash_spm_pkg::OFS_DATA;
   wire wr_cmd    = wr && req.paddr == flash_spm_pkg::OFS_CMD;
   wire mapped    = req.paddr == flash_spm_pkg::OFS_CTRL || req.paddr == flash_spm_pkg::OFS_PTR
                 || req.paddr == flash_spm_pkg::OFS_DATA || req.paddr == flash_spm_pkg::OFS_CMD
                 || req.paddr == flash_spm_pkg::OFS_RESULT || req.paddr == flash_spm_pkg::OFS_STATUS;

   // -----------------------------------------------------------------
   // Instruction strobes and command decode
   // -----------------------------------------------------------------
   wire        busy       = state_r != IDLE;
   wire        ee_busy    = ee_s2_r;
   wire        do_store   = wr_cmd && req.pwdata[1:0] == flash_spm_pkg::OP_STORE && !busy;
   wire        do_load    = wr_cmd && req.pwdata[1:0] == flash_spm_pkg::OP_LOAD && !busy;
   wire [3:0]  cmd        = ctrl_r[3:0] & flash_spm_pkg::CMD_MASK;
   wire        armed      = win_r != 3'h0 && !ee_busy;
   wire        go_erase   = do_store && armed && cmd == flash_spm_pkg::CMD_ERASE[3:0];
   wire        go_fill    = do_store && armed && cmd == flash_spm_pkg::CMD_LOAD[3:0];
   wire        go_write   = do_store && armed && cmd == flash_spm_pkg::CMD_WRITE[3:0];
   wire        lfrd_live  = armed && cmd == flash_spm_pkg::CMD_LFRD[3:0]
                         && win_r > (flash_spm_pkg::SPM_WINDOW - flash_spm_pkg::LPM_WINDOW);
   wire        go_fuse    = do_load && lfrd_live;
   wire        timer_end  = busy && timer_r == TW'(1);

   // Pointer split: word in page and page index
   wire [WORD_BITS-1:0] ptr_word = ptr_r[WORD_BITS:1];
   wire [PAGE_BITS-1:0] ptr_page = ptr_r[AW:WORD_BITS+1];
   wire                 ptr_byte = ptr_r[0];

   // Partial buffer lost when an EEPROM write starts
   wire ee_start  = ee_busy && !ee_prev_r;
   wire buf_clear = (timer_end && state_r == WRITING)
                 || (wr_ctrl && req.pwdata[flash_spm_pkg::BIT_FLUSH]) || (ee_start && buf_count != '0);

   assign buf_raddr = timer_r[WORD_BITS-1:0];

   // Fuse and lock lookup, programmed bits stored as zero
   wire [7:0] fuse_val = ptr_r == flash_spm_pkg::PTR_LOCK      ? LOCK_BITS
                       : ptr_r == flash_spm_pkg::PTR_FUSE_HIGH ? FUSE_HIGH
                       : ptr_r == flash_spm_pkg::PTR_FUSE_EXT  ? FUSE_EXT
                       : ptr_r == flash_spm_pkg::PTR_FUSE_LOW  ? FUSE_LOW
                       : 8'hff;
   wire [15:0] rd_word = flash_r[ptr_r[AW:1]];
   wire [7:0]  rd_byte = ptr_byte ? rd_word[15:8] : rd_word[7:0];

   page_buffer #(
      .WORDS (1 << WORD_BITS),
      .AW    (WORD_BITS)
   ) u_buf (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_clear (buf_clear),
      .i_we    (go_fill),
      .i_waddr (ptr_word),
      .i_wdata (data_r),
      .i_raddr (buf_raddr),
      .o_rdata (buf_rdata),
      .o_count (buf_count)
   );

   // -----------------------------------------------------------------
   // Sequencer next state
   // -----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         IDLE:
         begin
            if (go_erase)
               state_nxt = ERASING;
            else if (go_write)
               state_nxt = WRITING;
         end
         ERASING, WRITING:
         begin
            if (timer_end)
               state_nxt = IDLE;
         end
         default:
            state_nxt = IDLE;
      endcase
   end

   // -----------------------------------------------------------------
   // EEPROM busy synchroniser
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         ee_s1_r   <= 1'b0;
         ee_s2_r   <= 1'b0;
         ee_prev_r <= 1'b0;
      end
      else
      begin
         ee_s1_r   <= i_EEPROM_BUSY;
         ee_s2_r   <= ee_s1_r;
         ee_prev_r <= ee_s2_r;
      end
   end

   // -----------------------------------------------------------------
   // Control register and timed window
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         ctrl_r <= 8'h00;
         win_r  <= 3'h0;
      end
      else if (wr_ctrl && !busy)
      begin
         ctrl_r <= {req.pwdata[7], 3'h0, req.pwdata[3:0]};
         win_r  <= flash_spm_pkg::SPM_WINDOW;
      end
      else if (go_fuse || go_fill || timer_end)
      begin
         ctrl_r[3:0] <= 4'h0;
         win_r       <= 3'h0;
      end
      else if (win_r == 3'h1 || (!lfrd_live && cmd == flash_spm_pkg::CMD_LFRD[3:0] && !busy))
      begin
         if (!busy && !go_erase && !go_write)
            ctrl_r[3:0] <= 4'h0;
         win_r <= 3'h0;
      end
      else if (win_r != 3'h0 && !go_erase && !go_write)
      begin
         win_r <= win_r - 3'h1;
      end
      else
      begin
         win_r <= 3'h0;
      end
   end

   // -----------------------------------------------------------------
   // Pointer, data pair, readback result
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         ptr_r    <= 16'h0000;
         data_r   <= 16'h0000;
         result_r <= 8'h00;
      end
      else
      begin
         if (wr_ptr && !busy)
            ptr_r <= req.pwdata[15:0];
         if (wr_data && !busy)
            data_r <= req.pwdata[15:0];
         if (go_fuse)
            result_r <= fuse_val;
         else if (do_load)
            result_r <= rd_byte;
      end
   end

   // -----------------------------------------------------------------
   // Flash operation timer and page
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         state_r   <= IDLE;
         timer_r   <= '0;
         op_page_r <= '0;
         done_r    <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (go_erase || go_write)
         begin
            timer_r   <= TW'(PROG_TIME);
            op_page_r <= ptr_page;
         end
         else if (busy)
            timer_r <= timer_r - 1'b1;
         if (timer_end)
            done_r <= 1'b1;
         else if (wr_ctrl)
            done_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Flash array, one page word per cycle during the last counts
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (busy && timer_r <= TW'(1 << WORD_BITS) && timer_r != '0)
      begin
         if (state_r == ERASING)
            flash_r[{op_page_r, timer_r[WORD_BITS-1:0]}] <= 16'hffff;
         else
            flash_r[{op_page_r, timer_r[WORD_BITS-1:0]}] <= buf_rdata;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         prdata_r <= 32'h0000_0000;
         stall_r  <= 1'b0;
         irq_r    <= 1'b0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= req.psel && !req.penable;
         pslverr_r <= req.psel && !req.penable && !mapped;
         stall_r  <= state_nxt != IDLE;
         irq_r    <= ctrl_r[flash_spm_pkg::BIT_IRQEN] && state_nxt == IDLE
                  && !ee_busy && !(wr_ctrl ? req.pwdata[0] : ctrl_r[0]);
         if (req.psel && !req.penable && !req.pwrite)
         begin
            case (req.paddr)
               flash_spm_pkg::OFS_CTRL:   prdata_r <= {24'h0, ctrl_r};
               flash_spm_pkg::OFS_PTR:    prdata_r <= {16'h0, ptr_r};
               flash_spm_pkg::OFS_DATA:   prdata_r <= {16'h0, data_r};
               flash_spm_pkg::OFS_RESULT: prdata_r <= {24'h0, result_r};
               flash_spm_pkg::OFS_STATUS: prdata_r <= {22'h0, buf_count, 3'h0}
                                                   | {29'h0, done_r, irq_r, busy};
               default:                   prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign o_PRDATA    = prdata_r;
   assign o_PREADY    = pready_r;
   assign o_PSLVERR   = pslverr_r;
   assign o_STALL     = stall_r;
   assign o_READY_IRQ = irq_r;

endmodule : flash_self_program_sequencer

`default_nettype wire

// *** spm_props.sv ***
/* Port checker for the flash self-program sequencer.
   Assumes a bind to the top module with PROG_TIME handed on. */
`timescale 1ns/1ps
`default_nettype none
module spm_props #(
   parameter int unsigned PROG_TIME = 100
) (
   input wire logic        I_CLK,
   input wire logic        I_RESET,
   input wire logic        i_PSEL,
   input wire logic        i_PENABLE,
   input wire logic        i_PWRITE,
   input wire logic [11:0] i_PADDR,
   input wire logic [31:0] i_PWDATA,
   input wire logic [31:0] o_PRDATA,
   input wire logic        o_PREADY,
   input wire logic        o_PSLVERR,
   input wire logic        i_EEPROM_BUSY,
   input wire logic        o_STALL,
   input wire logic        o_READY_IRQ
);
   // ----------
   // Helpers
   // ----------
   logic [31:0] stall_cnt_r;
   logic [2:0]  ee_idle_r;
   wire         acc   = i_PSEL & i_PENABLE & o_PREADY & i_PWRITE;
   wire         quiet = (ee_idle_r == 3'h7) & ~o_STALL;
   wire         store = acc & (i_PADDR == flash_spm_pkg::OFS_CMD) & (i_PWDATA[1:0] == flash_spm_pkg::OP_STORE);
   wire [7:0]   ctl   = (acc & (i_PADDR == flash_spm_pkg::OFS_CTRL)) ? i_PWDATA[7:0] : 8'h00;
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         stall_cnt_r <= 32'h0;
         ee_idle_r   <= 3'h0;
      end
      else
      begin
         stall_cnt_r <= ~o_STALL ? 32'h0 : stall_cnt_r + 32'h1;
         ee_idle_r   <= i_EEPROM_BUSY ? 3'h0 : ee_idle_r + {2'h0, ee_idle_r != 3'h7};
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   sequence cmd_seq(logic [7:0] v);
      quiet && ctl == v ##[1:4] store;
   endsequence
   sequence late_seq;
      quiet && ctl == 8'h03 ##1 (!store)[*4] ##1 store;
   endsequence
   // ----------
   // Assertions
   // ----------
   chk_erase_start: assert property (cmd_seq(8'h03) |=> o_STALL)
      else $error("erase did not stall");
   chk_write_start: assert property (cmd_seq(8'h05) |=> o_STALL)
      else $error("write did not stall");
   chk_load_free: assert property (cmd_seq(8'h01) |=> !o_STALL)
      else $error("load stalled");
   chk_late_store: assert property (late_seq |=> !o_STALL)
      else $error("late store started");
   chk_ee_blocks: assert property (i_EEPROM_BUSY [*4] ##0 (store && !o_STALL) |=> !o_STALL)
      else $error("store ran during EEPROM write");
   chk_prog_time: assert property ($fell(o_STALL) |-> stall_cnt_r == PROG_TIME)
      else $error("wrong program time");
   chk_irq_raise: assert property (quiet && ctl == 8'h80 |-> ##[1:2] o_READY_IRQ)
      else $error("ready irq missing");
   chk_irq_quiet: assert property (o_READY_IRQ |-> !o_STALL)
      else $error("ready irq while busy");
endmodule : spm_props
bind flash_self_program_sequencer spm_props #(.PROG_TIME(PROG_TIME)) i_spm_props (
   .I_CLK(I_CLK), .I_RESET(I_RESET), .i_PSEL(i_PSEL), .i_PENABLE(i_PENABLE), .i_PWRITE(i_PWRITE),
   .i_PADDR(i_PADDR), .i_PWDATA(i_PWDATA), .o_PRDATA(o_PRDATA), .o_PREADY(o_PREADY), .o_PSLVERR(o_PSLVERR),
   .i_EEPROM_BUSY(i_EEPROM_BUSY), .o_STALL(o_STALL), .o_READY_IRQ(o_READY_IRQ));
`default_nettype wire

// *** spm_core_model.sv ***
/* Core model: APB master for the store and load requests, EEPROM busy.
   Assumes one clock; obeys the stall output. */
`timescale 1ns/1ps
`default_nettype none
module spm_core_model (
   input  wire logic        i_clk,
   input  wire logic        i_stall,
   input  wire logic        i_ready,
   output var  logic        o_psel,
   output var  logic        o_penable,
   output var  logic        o_pwrite,
   output var  logic [11:0] o_paddr,
   output var  logic [31:0] o_pwdata,
   output var  logic        o_ee_busy
);
   bit held = 1'b0;
   initial
   begin
      {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_ee_busy} = '0;
   end
   // Keep holds psel for a back-to-back transfer
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input bit keep);
      if (!held)
      begin
         @(posedge i_clk);
         while (i_stall) // Core held
            @(posedge i_clk);
      end
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= w;
      o_paddr   <= a;
      o_pwdata  <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do
         @(posedge i_clk);
      while (!i_ready);
      held = keep;
      if (!keep)
      begin
         o_psel    <= 1'b0;
         o_penable <= 1'b0;
         o_paddr   <= ~a;
         o_pwdata  <= ~d;
      end
   endtask : xfer
   task automatic ee_set(input logic b);
      @(posedge i_clk);
      o_ee_busy <= b;
   endtask : ee_set
endmodule : spm_core_model
`default_nettype wire

// *** tb.sv ***
/* Self-checking bench for the flash self-program sequencer.
   Assumes the core model as APB master and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        I_CLK = 1'b0;
   logic        I_RESET = 1'b1;
   logic        psel, penable, pwrite, ee_busy, pready, pslverr, stall, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  fz [4] = '{8'h5a, 8'h3c, 8'hf7, 8'h9e};
   logic [64:0] q [$];
   logic [15:0] wd [3];
   logic [7:0]  pg, eb;
   int          slot [3] = '{5, 0, 63};
   int          n_errors = 0;
   int          tests_run = 0;
   flash_self_program_sequencer #(.PROG_TIME(100)) i_flash_self_program_sequencer (.I_CLK(I_CLK),
      .I_RESET(I_RESET), .i_PSEL(psel),
      .i_PENABLE(penable), .i_PWRITE(pwrite), .i_PADDR(paddr), .i_PWDATA(pwdata), .o_PRDATA(prdata),
      .o_PREADY(pready), .o_PSLVERR(pslverr), .i_EEPROM_BUSY(ee_busy), .o_STALL(stall), .o_READY_IRQ(irq));
   spm_core_model i_spm_core_model (.i_clk(I_CLK), .i_stall(stall), .i_ready(pready), .o_psel(psel),
      .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_ee_busy(ee_busy));
   initial
   begin
      forever #50 I_CLK = ~I_CLK;
   end
   // ----------
   // Tasks
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit keep = 1'b0);
      i_spm_core_model.xfer(1'b1, a, d, keep);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic err = 1'b0);
      q.push_back({err, m, e});
      i_spm_core_model.xfer(1'b0, a, 32'h0, 1'b0);
   endtask : rd
   task automatic cmd(input logic [7:0] c, input logic [1:0] op);
      wr(flash_spm_pkg::OFS_CTRL, {24'h0, c}, 1'b1);
      wr(flash_spm_pkg::OFS_CMD, {30'h0, op});
   endtask : cmd
   function automatic logic [31:0] ptr(input logic [7:0] p, input int w, input int b);
      return {17'h0, p, w[5:0], b[0]};
   endfunction : ptr
   task automatic load(input int s, input logic [15:0] d);
      wr(flash_spm_pkg::OFS_PTR, ptr(pg, s, 0));
      wr(flash_spm_pkg::OFS_DATA, {16'h0, d});
      cmd(flash_spm_pkg::CMD_LOAD, flash_spm_pkg::OP_STORE);
   endtask : load
   // ----------
   // Checking and stimulus
   // ----------
   always @(posedge I_CLK)
      if (psel && penable && pready && !pwrite)
      begin
         check(prdata & q[0][63:32], q[0][31:0]);
         check({31'h0, pslverr}, {31'h0, q[0][64]});
         void'(q.pop_front());
      end
   initial
   begin
      repeat (4000) @(posedge I_CLK);
      n_errors++;
      results();
   end
   initial
   begin
      void'($urandom(32'haa771bd7));
      pg = 8'($urandom_range(255, 1));
      repeat (10) @(posedge I_CLK);
      I_RESET <= 1'b0;
      rd(flash_spm_pkg::OFS_STATUS, 32'h3f8, 32'h0);
      rd(12'hffc, 32'h0, 32'h0, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wr(flash_spm_pkg::OFS_PTR, i);
         cmd(flash_spm_pkg::CMD_LFRD, flash_spm_pkg::OP_LOAD);
         rd(flash_spm_pkg::OFS_RESULT, 32'hff, {24'h0, fz[i]});
      end
      for (int i = 0; i < 3; i++)
      begin
         wd[i] = 16'($urandom);
         load(slot[i], wd[i]);
      end
      rd(flash_spm_pkg::OFS_STATUS, 32'h3f8, 32'h18);
      wr(flash_spm_pkg::OFS_PTR, ptr(pg, 63, 1));
      cmd(flash_spm_pkg::CMD_ERASE, flash_spm_pkg::OP_STORE);
      repeat (2) @(posedge I_CLK);
      wr(flash_spm_pkg::OFS_PTR, ptr(pg, 0, 0));
      cmd(flash_spm_pkg::CMD_WRITE, flash_spm_pkg::OP_STORE);
      repeat (2) @(posedge I_CLK);
      rd(flash_spm_pkg::OFS_STATUS, 32'h3f8, 32'h0);
      for (int i = 0; i < 4; i++)
         for (int b = 0; b < 2; b++)
         begin
            eb = (i == 3) ? 8'hff : (b == 1) ? wd[i][15:8] : wd[i][7:0];
            wr(flash_spm_pkg::OFS_PTR, ptr(pg, (i == 3) ? 1 : slot[i], b));
            wr(flash_spm_pkg::OFS_CMD, {30'h0, flash_spm_pkg::OP_LOAD});
            rd(flash_spm_pkg::OFS_RESULT, 32'hff, {24'h0, eb});
         end
      wr(flash_spm_pkg::OFS_CTRL, 32'h3);
      repeat (2) @(posedge I_CLK);
      wr(flash_spm_pkg::OFS_CMD, {30'h0, flash_spm_pkg::OP_STORE});
      @(posedge I_CLK);
      check({31'h0, stall}, 32'h0);
      load(2, 16'(~$urandom));
      i_spm_core_model.ee_set(1'b1);
      repeat (4) @(posedge I_CLK);
      cmd(flash_spm_pkg::CMD_ERASE, flash_spm_pkg::OP_STORE);
      @(posedge I_CLK);
      check({31'h0, stall}, 32'h0);
      i_spm_core_model.ee_set(1'b0);
      repeat (8) @(posedge I_CLK); // EEPROM idle before commands
      rd(flash_spm_pkg::OFS_STATUS, 32'h3f8, 32'h0);
      load(3, 16'($urandom));
      wr(flash_spm_pkg::OFS_CTRL, 32'h10);
      rd(flash_spm_pkg::OFS_STATUS, 32'h3f8, 32'h0);
      wr(flash_spm_pkg::OFS_CTRL, 32'h80);
      repeat (2) @(posedge I_CLK);
      check({31'h0, irq}, 32'h1);
      wr(flash_spm_pkg::OFS_CTRL, 32'h81);
      repeat (2) @(posedge I_CLK);
      check({31'h0, irq}, 32'h0);
      results();
   end
endmodule : tb
`default_nettype wire
